/* shared/bfr_regs.svh */
// Summary of operation
// - Dir1 reset low clears queue1 pointers, port-B out
// - Dir2 reset low clears queue2 pointers, port-A out
// - Dir1 master release latches method, offsets, width, endian
// - Dir2 master release latches queue2 setup, independent of dir1
// - Partial reset keeps configuration, clears pointers, port output register and mailbox flag
// - Bus match high: width select picks 9 or 18
// - Mode low serial; high parallel or default 8/16/64
// - Port-A direction high writes, low reads
// - Port-A data outputs released while port-A writes
// - Port-B direction low writes, high reads
// - Port-B data outputs released while port-B writes
// - Serial enable low shifts one offset bit per edge
// - Mailbox flags go empty after any queue reset
`ifndef BFR_REGS_SVH
`define BFR_REGS_SVH
`define BFR_ADDR_CONFIG 8'h00
`define BFR_ADDR_OFFSETS 8'h04
`define BFR_ADDR_POINTERS 8'h08
`define BFR_ADDR_IRQ_STATUS 8'h0c
`define BFR_ADDR_IRQ_MASK 8'h10
`define BFR_PTR_W 8
`define BFR_DATA_W 36
`define BFR_OFS_W 8
`define BFR_SERIAL_BITS 6'h20
`define BFR_MIN_RESET_EDGES 3'h4
`define BFR_IRQ_W 5
`define BFR_IRQ_DIR1_MASTER_RESET_N_DONE 0
`define BFR_IRQ_DIR2_MASTER_RESET_N_DONE 1
`define BFR_IRQ_SERIAL_DONE 2
`define BFR_IRQ_SHORT_RESET 3
`define BFR_IRQ_UNPAIRED 4
`define BFR_OFS_DEF8 8'h08
`define BFR_OFS_DEF16 8'h10
`define BFR_OFS_DEF64 8'h40
`define BFR_SEL_DEF64 2'h0
`define BFR_SEL_DEF16 2'h1
`define BFR_SEL_DEF8 2'h2
`define BFR_SEL_PARALLEL 2'h3
`endif

/* shared/bfr_pkg.sv */
package bfr_pkg;
  typedef enum logic [1:0] {BFR_W36, BFR_W18, BFR_W9} bfr_width_t;
  typedef enum logic [1:0] {BFR_LD_IDLE, BFR_LD_SHIFT, BFR_LD_DONE} bfr_load_state_t;
endpackage

/* verilog/bfr_sync.sv */
`timescale 1ns/1ps
module bfr_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_r[g] <= 1'b0;
          q_o[g] <= 1'b0;
        end else begin
          meta_r[g] <= d_i[g];
          q_o[g] <= meta_r[g];
        end
      end
    end
  endgenerate
endmodule

/* verilog/bfr_ctrl.sv */
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "bfr_regs.svh"
module bfr_ctrl
  import bfr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic dir1_master_reset_n_i,
  input wire logic dir2_master_reset_n_i,
  input wire logic dir1_partial_reset_n_i,
  input wire logic dir2_partial_reset_n_i,
  input wire logic bus_match_en_i,
  input wire logic byte_width_sel_i,
  input wire logic endian_sel_i,
  input wire logic serial_prog_mode_n_i,
  input wire logic offset_sel1_serial_en_i,
  input wire logic offset_sel0_serial_data_i,
  input wire logic porta_clk_i,
  input wire logic portb_clk_i,
  input wire logic porta_dir_i,
  input wire logic portb_dir_i,
  input wire logic portb_enable_i,
  output logic [`BFR_DATA_W-1:0] porta_data_o,
  output logic porta_data_oe_o,
  output logic [`BFR_DATA_W-1:0] portb_data_o,
  output logic portb_data_oe_o,
  output logic mailbox1_full_n_o,
  output logic mailbox2_full_n_o,
  output bfr_width_t portb_width_o,
  output logic endian_o
);
  logic [14:0] pin_s;
  logic dir1_master_reset_n_s, dir2_master_reset_n_s, dir1_partial_reset_n_s, dir2_partial_reset_n_s, bm_s, bsz_s, end_s, spm_s, sen_s, sd_s;
  logic pa_clk_s, pb_clk_s, pa_dir_s, pb_dir_s, pb_en_s;
  logic dir1_master_reset_n_d_r, dir2_master_reset_n_d_r, pa_clk_d_r, pb_clk_d_r;
  logic dir1_master_reset_n_rise, dir2_master_reset_n_rise, pa_rise, pb_rise, q1_clear, q2_clear;
  logic [`BFR_PTR_W-1:0] q1_wr_ptr_r, q1_rd_ptr_r, q2_wr_ptr_r, q2_rd_ptr_r;
  logic [`BFR_DATA_W-1:0] pa_out_r, pb_out_r;
  bfr_width_t width_r;
  logic q1_serial_r, q2_serial_r;
  logic [1:0] q1_sel_r, q2_sel_r;
  logic [4*`BFR_OFS_W-1:0] offsets_r;
  bfr_load_state_t load_state_r;
  logic [5:0] load_cnt_r;
  logic [2:0] a_edges_r, b_edges_r;
  logic [`BFR_IRQ_W-1:0] irq_status_r, irq_mask_r, irq_event;
  logic wb_req, wb_wr, wb_rd_status;
  logic [31:0] rd_data;

  bfr_sync #(.W(15)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({dir1_master_reset_n_i, dir2_master_reset_n_i, dir1_partial_reset_n_i,
          dir2_partial_reset_n_i, bus_match_en_i, byte_width_sel_i, endian_sel_i,
          serial_prog_mode_n_i, offset_sel1_serial_en_i, offset_sel0_serial_data_i,
          porta_clk_i, portb_clk_i, porta_dir_i, portb_dir_i, portb_enable_i}),
    .q_o(pin_s)
  );
  assign {dir1_master_reset_n_s, dir2_master_reset_n_s, dir1_partial_reset_n_s, dir2_partial_reset_n_s, bm_s, bsz_s, end_s, spm_s, sen_s, sd_s,
          pa_clk_s, pb_clk_s, pa_dir_s, pb_dir_s, pb_en_s} = pin_s;

  function automatic logic [`BFR_OFS_W-1:0] default_ofs(input logic [1:0] sel);
    logic [`BFR_OFS_W-1:0] v;
    v = `BFR_OFS_DEF64;
    if (sel == `BFR_SEL_DEF16) begin
      v = `BFR_OFS_DEF16;
    end else if (sel == `BFR_SEL_DEF8) begin
      v = `BFR_OFS_DEF8;
    end
    return v;
  endfunction

  // Edge detection works on the second synchroniser stage only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir1_master_reset_n_d_r <= 1'b0;
      dir2_master_reset_n_d_r <= 1'b0;
      pa_clk_d_r <= 1'b0;
      pb_clk_d_r <= 1'b0;
    end else begin
      dir1_master_reset_n_d_r <= dir1_master_reset_n_s;
      dir2_master_reset_n_d_r <= dir2_master_reset_n_s;
      pa_clk_d_r <= pa_clk_s;
      pb_clk_d_r <= pb_clk_s;
    end
  end
  assign dir1_master_reset_n_rise = dir1_master_reset_n_s & ~dir1_master_reset_n_d_r;
  assign dir2_master_reset_n_rise = dir2_master_reset_n_s & ~dir2_master_reset_n_d_r;
  assign pa_rise = pa_clk_s & ~pa_clk_d_r;
  assign pb_rise = pb_clk_s & ~pb_clk_d_r;
  assign q1_clear = ~dir1_master_reset_n_s | ~dir1_partial_reset_n_s;
  assign q2_clear = ~dir2_master_reset_n_s | ~dir2_partial_reset_n_s;

  // Queue pointers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q1_wr_ptr_r <= '0;
      q1_rd_ptr_r <= '0;
      pb_out_r <= '0;
    end else if (q1_clear) begin
      q1_wr_ptr_r <= '0;
      q1_rd_ptr_r <= '0;
      pb_out_r <= '0;
    end else begin
      if (pa_rise && pa_dir_s) begin
        q1_wr_ptr_r <= q1_wr_ptr_r + 1'b1;
      end
      if (pb_rise && pb_en_s && pb_dir_s) begin
        q1_rd_ptr_r <= q1_rd_ptr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q2_wr_ptr_r <= '0;
      q2_rd_ptr_r <= '0;
      pa_out_r <= '0;
    end else if (q2_clear) begin
      q2_wr_ptr_r <= '0;
      q2_rd_ptr_r <= '0;
      pa_out_r <= '0;
    end else begin
      if (pb_rise && pb_en_s && !pb_dir_s) begin
        q2_wr_ptr_r <= q2_wr_ptr_r + 1'b1;
      end
      if (pa_rise && !pa_dir_s) begin
        q2_rd_ptr_r <= q2_rd_ptr_r + 1'b1;
      end
    end
  end

  assign porta_data_o = pa_out_r;
  assign portb_data_o = pb_out_r;
  assign porta_data_oe_o = ~pa_dir_s;
  assign portb_data_oe_o = pb_dir_s;

  // Mailbox flags return to empty on any reset of their queue
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mailbox1_full_n_o <= 1'b1;
      mailbox2_full_n_o <= 1'b1;
    end else begin
      if (q1_clear) begin
        mailbox1_full_n_o <= 1'b1;
      end
      if (q2_clear) begin
        mailbox2_full_n_o <= 1'b1;
      end
    end
  end

  // Static configuration is captured only on master release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      width_r <= BFR_W36;
      endian_o <= 1'b0;
      q1_serial_r <= 1'b0;
      q1_sel_r <= `BFR_SEL_DEF64;
    end else if (dir1_master_reset_n_rise) begin
      if (!bm_s) begin
        width_r <= BFR_W36;
      end else if (bsz_s) begin
        width_r <= BFR_W9;
      end else begin
        width_r <= BFR_W18;
      end
      endian_o <= end_s;
      q1_serial_r <= ~spm_s;
      q1_sel_r <= {sen_s, sd_s};
    end
  end
  assign portb_width_o = width_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q2_serial_r <= 1'b0;
      q2_sel_r <= `BFR_SEL_DEF64;
    end else if (dir2_master_reset_n_rise) begin
      q2_serial_r <= ~spm_s;
      q2_sel_r <= {sen_s, sd_s};
    end
  end

  // Offset registers: defaults at master release or serial shifting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      offsets_r <= {4{`BFR_OFS_DEF64}};
    end else begin
      if (dir1_master_reset_n_rise && spm_s && ({sen_s, sd_s} != `BFR_SEL_PARALLEL)) begin
        offsets_r[23:0] <= {3{default_ofs({sen_s, sd_s})}};
      end
      if (dir2_master_reset_n_rise && spm_s && ({sen_s, sd_s} != `BFR_SEL_PARALLEL)) begin
        offsets_r[31:24] <= default_ofs({sen_s, sd_s});
      end
      if (load_state_r == BFR_LD_SHIFT && pa_rise && !sen_s) begin
        offsets_r <= {offsets_r[30:0], sd_s};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_state_r <= BFR_LD_IDLE;
      load_cnt_r <= '0;
    end else if (!dir1_master_reset_n_s) begin
      load_state_r <= BFR_LD_IDLE;
      load_cnt_r <= '0;
    end else begin
      case (load_state_r)
        BFR_LD_IDLE: begin
          if (dir1_master_reset_n_rise) begin
            load_state_r <= spm_s ? BFR_LD_DONE : BFR_LD_SHIFT;
          end
        end
        BFR_LD_SHIFT: begin
          if (pa_rise && !sen_s) begin
            load_cnt_r <= load_cnt_r + 1'b1;
            if (load_cnt_r == `BFR_SERIAL_BITS - 6'h1) begin
              load_state_r <= BFR_LD_DONE;
            end
          end
        end
        default: begin
          load_state_r <= BFR_LD_DONE;
        end
      endcase
    end
  end

  // Count port clock edges during master reset to flag a short pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_edges_r <= '0;
      b_edges_r <= '0;
    end else if (dir1_master_reset_n_s && dir2_master_reset_n_s) begin
      a_edges_r <= '0;
      b_edges_r <= '0;
    end else begin
      if (pa_rise && a_edges_r != `BFR_MIN_RESET_EDGES) begin
        a_edges_r <= a_edges_r + 3'h1;
      end
      if (pb_rise && b_edges_r != `BFR_MIN_RESET_EDGES) begin
        b_edges_r <= b_edges_r + 3'h1;
      end
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[`BFR_IRQ_DIR1_MASTER_RESET_N_DONE] = dir1_master_reset_n_rise;
    irq_event[`BFR_IRQ_DIR2_MASTER_RESET_N_DONE] = dir2_master_reset_n_rise;
    irq_event[`BFR_IRQ_SERIAL_DONE] = (load_state_r == BFR_LD_SHIFT) && pa_rise && !sen_s &&
                                      (load_cnt_r == `BFR_SERIAL_BITS - 6'h1);
    irq_event[`BFR_IRQ_SHORT_RESET] = (dir1_master_reset_n_rise || dir2_master_reset_n_rise) &&
      ((a_edges_r < `BFR_MIN_RESET_EDGES) || (b_edges_r < `BFR_MIN_RESET_EDGES));
    irq_event[`BFR_IRQ_UNPAIRED] = dir1_master_reset_n_rise ^ dir2_master_reset_n_rise;
  end

  // Wishbone classic slave, one wait state
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;
  assign wb_rd_status = wb_req & ~wb_we_i & (wb_adr_i == `BFR_ADDR_IRQ_STATUS);

  always_comb begin
    rd_data = 32'h0000_0000;
    if (wb_adr_i == `BFR_ADDR_CONFIG) begin
      rd_data[11:0] = {mailbox2_full_n_o, mailbox1_full_n_o,
                       load_state_r == BFR_LD_DONE, q2_sel_r, q2_serial_r,
                       q1_sel_r, q1_serial_r, endian_o, width_r};
    end else if (wb_adr_i == `BFR_ADDR_OFFSETS) begin
      rd_data = offsets_r;
    end else if (wb_adr_i == `BFR_ADDR_POINTERS) begin
      rd_data = {q2_rd_ptr_r, q2_wr_ptr_r, q1_rd_ptr_r, q1_wr_ptr_r};
    end else if (wb_adr_i == `BFR_ADDR_IRQ_STATUS) begin
      rd_data[`BFR_IRQ_W-1:0] = irq_status_r;
    end else if (wb_adr_i == `BFR_ADDR_IRQ_MASK) begin
      rd_data[`BFR_IRQ_W-1:0] = irq_mask_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= '0;
    end else if (wb_wr && wb_adr_i == `BFR_ADDR_IRQ_MASK && wb_sel_i[0]) begin
      irq_mask_r <= wb_dat_i[`BFR_IRQ_W-1:0];
    end
  end

  // New events win over the clear-on-read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= (wb_rd_status ? '0 : irq_status_r) | irq_event;
    end
  end
  assign irq_o = |(irq_status_r & irq_mask_r);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_q1_released;
    dir1_master_reset_n_s && dir1_partial_reset_n_s;
  endsequence
  sequence s_pa_write;
    pa_rise && pa_dir_s && !q1_clear;
  endsequence
  sequence s_pb_read;
    pb_rise && pb_en_s && pb_dir_s && !q1_clear;
  endsequence

  AST_Q1_CLEAR: assert property (q1_clear |=> (q1_wr_ptr_r == '0) && (q1_rd_ptr_r == '0)
    && (pb_out_r == '0)) else $error("queue1 not cleared by reset");
  AST_Q2_CLEAR: assert property (!dir2_partial_reset_n_s |=> (q2_wr_ptr_r == '0) && (q2_rd_ptr_r == '0)
    && (pa_out_r == '0)) else $error("queue2 not cleared by reset");
  AST_WIDTH_LATCH: assert property (dir1_master_reset_n_rise |=>
    width_r == (!$past(bm_s) ? BFR_W36 : ($past(bsz_s) ? BFR_W9 : BFR_W18)))
    else $error("port-B width not latched");
  AST_Q2_LATCH: assert property (dir2_master_reset_n_rise |=> q2_serial_r == !$past(spm_s))
    else $error("queue2 method not latched");
  AST_PARTIAL_KEEP: assert property (dir1_master_reset_n_s && dir1_master_reset_n_d_r && !dir1_partial_reset_n_s |=>
    $stable(width_r) && $stable(endian_o) && $stable(q1_serial_r))
    else $error("partial reset changed configuration");
  AST_PA_OE: assert property (pa_dir_s |-> !porta_data_oe_o ##1
    (porta_data_oe_o == !pa_dir_s))
    else $error("port-A output driven during write");
  AST_PB_OE: assert property (!pb_dir_s |-> !portb_data_oe_o)
    else $error("port-B output driven during write");
  AST_SERIAL_SHIFT: assert property ((load_state_r == BFR_LD_SHIFT) && pa_rise &&
    !sen_s |=> (offsets_r[0] == $past(sd_s)) &&
    (offsets_r[31:1] == $past(offsets_r[30:0])))
    else $error("serial offset bit not shifted");
  AST_MAILBOX_EMPTY: assert property (q1_clear |=> mailbox1_full_n_o)
    else $error("mailbox1 flag not empty after reset");
  AST_PA_WRITE: assert property (s_q1_released ##0 s_pa_write |=>
    q1_wr_ptr_r == $past(q1_wr_ptr_r) + 8'h01) else $error("port-A write not counted");
  AST_PB_READ: assert property (s_q1_released ##0 s_pb_read |=>
    q1_rd_ptr_r == $past(q1_rd_ptr_r) + 8'h01) else $error("port-B read not counted");
  AST_PB_IDLE: assert property (!pb_en_s && !q1_clear |=> $stable(q1_rd_ptr_r))
    else $error("port-B moved without enable");
  AST_WB_ACK: assert property (wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus acknowledge not a single pulse");
endmodule

/* verif/bfr_port_model.sv */
`timescale 1ns/1ps
module bfr_port_model (
  input wire logic clk_i,
  output logic porta_clk_o,
  output logic portb_clk_o,
  output logic porta_dir_o,
  output logic portb_dir_o,
  output logic portb_enable_o,
  output logic serial_en_o,
  output logic serial_data_o
);
  initial begin
    porta_clk_o = 1'b0;
    portb_clk_o = 1'b0;
    porta_dir_o = 1'b0;
    portb_dir_o = 1'b1;
    portb_enable_o = 1'b0;
    serial_en_o = 1'b1;
    serial_data_o = 1'b0;
  end
  // Half periods of three system clocks keep every port edge visible to the block
  task automatic edges_a(input int n, input logic dir);
    for (int i = 0; i < n; i++) begin
      porta_dir_o <= dir;
      repeat (3) @(posedge clk_i);
      porta_clk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      porta_clk_o <= 1'b0;
    end
  endtask
  task automatic edges_b(input int n, input logic dir, input logic en);
    // Spare edge so a following call never drives the enable twice at once
    @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      portb_dir_o <= dir;
      portb_enable_o <= en;
      repeat (3) @(posedge clk_i);
      portb_clk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      portb_clk_o <= 1'b0;
    end
    portb_enable_o <= 1'b0;
  endtask
  task automatic set_sel(input logic s1, input logic s0);
    serial_en_o <= s1;
    serial_data_o <= s0;
  endtask
  // First bit sent is the most significant; the data line is left inverted afterwards
  task automatic shift_bits(input logic [31:0] v);
    for (int i = 31; i >= 0; i--) begin
      serial_en_o <= 1'b0;
      serial_data_o <= v[i];
      repeat (3) @(posedge clk_i);
      porta_clk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      porta_clk_o <= 1'b0;
    end
    serial_en_o <= 1'b1;
    serial_data_o <= ~v[0];
  endtask
endmodule

/* verif/bidir_fifo_reset_port_config_tb.sv */
`timescale 1ns/1ps
`include "bfr_regs.svh"
`define CHK(got, exp, msg) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("BAD t=%0t %s", $time, msg); \
  end \
end
module bidir_fifo_reset_port_config_tb import bfr_pkg::*; ();
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, irq;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  logic d1m_n, d2m_n, d1p_n, d2p_n, bm, ws, endian, mode_n;
  logic a_clk, b_clk, a_dir, b_dir, b_en, s_en, s_dat;
  logic [`BFR_DATA_W-1:0] a_data, b_data;
  logic a_oe, b_oe, mbx1_n, mbx2_n, endian_q;
  bfr_width_t width_q;
  int failures = 0;
  int checked = 0;

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  bfr_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
    .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .irq_o(irq),
    .dir1_master_reset_n_i(d1m_n), .dir2_master_reset_n_i(d2m_n),
    .dir1_partial_reset_n_i(d1p_n), .dir2_partial_reset_n_i(d2p_n),
    .bus_match_en_i(bm), .byte_width_sel_i(ws), .endian_sel_i(endian),
    .serial_prog_mode_n_i(mode_n), .offset_sel1_serial_en_i(s_en),
    .offset_sel0_serial_data_i(s_dat), .porta_clk_i(a_clk), .portb_clk_i(b_clk),
    .porta_dir_i(a_dir), .portb_dir_i(b_dir), .portb_enable_i(b_en),
    .porta_data_o(a_data), .porta_data_oe_o(a_oe), .portb_data_o(b_data),
    .portb_data_oe_o(b_oe), .mailbox1_full_n_o(mbx1_n), .mailbox2_full_n_o(mbx2_n),
    .portb_width_o(width_q), .endian_o(endian_q));

  bfr_port_model P (.clk_i(clk_i), .porta_clk_o(a_clk), .portb_clk_o(b_clk),
    .porta_dir_o(a_dir), .portb_dir_o(b_dir), .portb_enable_o(b_en),
    .serial_en_o(s_en), .serial_data_o(s_dat));

  task automatic print_verdict();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] wd,
                         output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 4'hf;
    wb_adr <= a;
    wb_dat_w <= wd;
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    `CHK(wb_ack, 1'b1, "bus answer missing")
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp,
                        input string msg);
    logic [31:0] d;
    wb_xfer(1'b0, a, 32'h0, d);
    `CHK(d & mask, exp, msg)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    wb_xfer(1'b1, a, v, d);
  endtask

  // Width select only moves under the mid-run system reset, never afterwards
  task automatic master_reset(input logic b, input logic w, input logic e, input logic m,
                              input logic s1, input logic s0, input int ea, input int eb,
                              input bit skew);
    @(posedge clk_i);
    d1m_n <= 1'b0;
    d2m_n <= 1'b0;
    bm <= b;
    ws <= w;
    endian <= e;
    mode_n <= m;
    P.set_sel(s1, s0);
    P.edges_a(ea, 1'b1);
    P.edges_b(eb, 1'b0, 1'b1);
    @(posedge clk_i);
    d1m_n <= 1'b1;
    if (skew) begin
      @(posedge clk_i);
    end
    d2m_n <= 1'b1;
    wait_cyc(6);
  endtask

  initial begin
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we, wb_sel, wb_adr, wb_dat_w} = '0;
    {d1m_n, d2m_n, d1p_n, d2p_n} = 4'h3;
    {bm, ws, endian, mode_n} = 4'hf;
    wait_cyc(3);
    rst_i <= 1'b0;
    master_reset(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 4, 4, 0);
    `CHK(irq, 1'b0, "irq while masked")
    `CHK(width_q, BFR_W9, "width not 9")
    `CHK(endian_q, 1'b1, "endian not latched")
    rd_chk(`BFR_ADDR_CONFIG, 32'hdff, 32'hd26, "config after master");
    rd_chk(`BFR_ADDR_OFFSETS, 32'hffffffff, 32'h08080808, "default 8");
    rd_chk(`BFR_ADDR_IRQ_STATUS, 32'h1f, 32'h03, "release events");
    rd_chk(`BFR_ADDR_IRQ_STATUS, 32'h1f, 32'h00, "status not cleared");
    rd_chk(`BFR_ADDR_POINTERS, 32'hffffffff, 32'h0, "pointers after master");
    $display("test 1 master reset done");
    P.edges_a(3, 1'b1);
    wait_cyc(4);
    `CHK(a_oe, 1'b0, "port A drives while writing")
    P.edges_a(2, 1'b0);
    wait_cyc(4);
    `CHK(a_oe, 1'b1, "port A idle while reading")
    P.edges_b(4, 1'b0, 1'b1);
    wait_cyc(4);
    `CHK(b_oe, 1'b0, "port B drives while writing")
    P.edges_b(1, 1'b1, 1'b1);
    P.edges_b(2, 1'b1, 1'b0);
    wait_cyc(6);
    `CHK(b_oe, 1'b1, "port B idle while reading")
    rd_chk(`BFR_ADDR_POINTERS, 32'hffffffff, 32'h02040103, "pointer moves");
    $display("test 2 port transfers done");
    d1p_n <= 1'b0;
    wait_cyc(6);
    `CHK(b_data, 36'h0, "port B register not cleared")
    d1p_n <= 1'b1;
    wait_cyc(6);
    `CHK(mbx1_n, 1'b1, "mailbox 1 not empty")
    rd_chk(`BFR_ADDR_POINTERS, 32'hffffffff, 32'h02040000, "partial 1");
    rd_chk(`BFR_ADDR_CONFIG, 32'hdff, 32'hd26, "config lost");
    rd_chk(`BFR_ADDR_OFFSETS, 32'hffffffff, 32'h08080808, "offsets lost");
    d2p_n <= 1'b0;
    wait_cyc(6);
    `CHK(a_data, 36'h0, "port A register not cleared")
    d2p_n <= 1'b1;
    wait_cyc(6);
    `CHK(mbx2_n, 1'b1, "mailbox 2 not empty")
    rd_chk(`BFR_ADDR_POINTERS, 32'hffffffff, 32'h0, "partial 2");
    $display("test 3 partial resets done");
    rst_i <= 1'b1;
    d1m_n <= 1'b0;
    d2m_n <= 1'b0;
    ws <= 1'b0;
    wait_cyc(3);
    rst_i <= 1'b0;
    `CHK(width_q, BFR_W36, "width after system reset")
    master_reset(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 4, 4, 0);
    rd_chk(`BFR_ADDR_CONFIG, 32'hf, 32'h9, "width 18 serial");
    P.shift_bits(32'ha5c31e77);
    wait_cyc(6);
    rd_chk(`BFR_ADDR_OFFSETS, 32'hffffffff, 32'ha5c31e77, "serial offsets");
    rd_chk(`BFR_ADDR_IRQ_STATUS, 32'h1f, 32'h07, "serial done event");
    $display("test 4 serial load done");
    wr(`BFR_ADDR_IRQ_MASK, 32'h08);
    rd_chk(`BFR_ADDR_IRQ_MASK, 32'h1f, 32'h08, "mask readback");
    wr(8'h20, 32'hffffffff);
    rd_chk(8'h20, 32'hffffffff, 32'h0, "unmapped read");
    master_reset(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 2, 4, 1);
    `CHK(irq, 1'b1, "irq not raised")
    `CHK(width_q, BFR_W36, "width not 36")
    rd_chk(`BFR_ADDR_OFFSETS, 32'hffffffff, 32'h10101010, "default 16");
    rd_chk(`BFR_ADDR_IRQ_STATUS, 32'h1f, 32'h1b, "short and split release");
    wait_cyc(1);
    `CHK(irq, 1'b0, "irq not cleared")
    $display("test 5 interrupts done");
    print_verdict();
  end

  initial begin
    wait_cyc(20000);
    failures++;
    print_verdict();
  end
endmodule
